// ===== rtl/mapf_pkg.sv
// Constants, register map and carrier types of the moving-average power filter
package mapf_pkg;
  // Sample and clock timing
  localparam int unsigned MAPF_CLK_NS = 40;
  localparam int unsigned MAPF_SMP_PERIOD_MS = 50;
  localparam int unsigned MAPF_SMP_CYC = (MAPF_SMP_PERIOD_MS * 1000000) / MAPF_CLK_NS;
  localparam int unsigned MAPF_OUT_GAP_MS = 5;
  localparam int unsigned MAPF_OUT_GAP_CYC = (MAPF_OUT_GAP_MS * 1000000) / MAPF_CLK_NS;
  // Window length in tenths of a second
  localparam int unsigned MAPF_TENTH_MS = 100;
  localparam int unsigned MAPF_SMP_PER_TENTH = MAPF_TENTH_MS / MAPF_SMP_PERIOD_MS;
  localparam logic [7:0] MAPF_WIN_MAX = 8'hc8;
  localparam logic [7:0] MAPF_WIN_R0 = 8'h1c;
  localparam logic [7:0] MAPF_WIN_R1 = 8'h08;
  localparam logic [7:0] MAPF_WIN_FAST = 8'h00;
  // Range codes
  localparam logic [2:0] MAPF_RANGE_AUTO = 3'h7;
  localparam logic [2:0] MAPF_RANGE_1 = 3'h1;
  // Register byte offsets
  localparam logic [7:0] MAPF_OFS_CTRL = 8'h00;
  localparam logic [7:0] MAPF_OFS_WIN = 8'h04;
  localparam logic [7:0] MAPF_OFS_RANGE = 8'h08;
  localparam logic [7:0] MAPF_OFS_THR = 8'h0c;
  localparam logic [7:0] MAPF_OFS_LOWLIM = 8'h10;
  localparam logic [7:0] MAPF_OFS_CMD = 8'h14;
  localparam logic [7:0] MAPF_OFS_AVG = 8'h18;
  localparam logic [7:0] MAPF_OFS_STAT = 8'h1c;
  localparam logic [7:0] MAPF_OFS_MASK = 8'h20;
  localparam logic [7:0] MAPF_OFS_FILL = 8'h24;
  // Field positions
  localparam int unsigned MAPF_CMD_CLR_BIT = 0;
  // Control word, reset value and layout
  typedef struct packed {
    logic settled; // Hold output until window full
    logic use_def; // Use per-range default window
    logic fast;    // Fast mode defaults
    logic auto_en; // Auto clear on large change
  } mapf_ctrl_s;
  localparam mapf_ctrl_s MAPF_CTRL_RST = 4'h4;
  // Sticky status word, also the mask layout
  typedef struct packed {
    logic uncal;   // Below range limit seen
    logic auto_clr; // Auto clear happened
    logic out_rdy; // New average issued
  } mapf_stat_s;
  localparam logic [2:0] MAPF_MASK_RST = 3'h0;
  localparam logic [7:0] MAPF_RANGE_RST = 8'h07;
  // Filter sequencer states
  typedef enum logic [1:0] {
    MAPF_IDLE,
    MAPF_DIV,
    MAPF_OUT
  } mapf_state_e;
endpackage

// ===== rtl/mapf_filter.sv
// Moving-average power filter with APB register slave
//
// The implementer's own choices: the APB register port and the register offsets.
`timescale 1ns/1ns
// Overview of operation
// - Output is equal-weight mean over window
// - Window settable from zero to twenty seconds
// - Normal defaults: range0 2.8s, others 0.8s
// - Fast defaults: 2.8s, 0.8s, then zero
// - Sample every 50 ms; first output fast
// - Filling window divides by samples so far
// - Full window gives linear ramp on step
// - New sample displaces oldest when full
// - Auto option clears on large change
// - Writing different window length clears filter
// - Trigger clears filter immediately
// - Outputs limited to about 200 per second
// - Settled mode withholds output until settled
// - Fixed range active unless autorange selected
// - Fixed range below limit flags uncalibrated
module mapf_filter
  import mapf_pkg::*;
#(
  parameter int unsigned SMP_W = 16,
  parameter int unsigned SMP_CYC = MAPF_SMP_CYC,
  parameter int unsigned OUT_GAP_CYC = MAPF_OUT_GAP_CYC
) (
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic [SMP_W-1:0] smp_data,
  input wire logic [2:0] meas_range,
  input wire logic trig,
  output logic smp_take,
  output logic [SMP_W-1:0] avg_data,
  output logic avg_valid,
  output logic uncal,
  output logic irq
);
  // Derived sizes
  localparam int unsigned DEPTH = 200 * MAPF_SMP_PER_TENTH;
  localparam int unsigned LEN_W = $clog2(DEPTH + 1);
  localparam int unsigned SUM_W = SMP_W + LEN_W;
  localparam int unsigned TCK_W = $clog2(SMP_CYC);
  localparam int unsigned GAP_W = $clog2(OUT_GAP_CYC + 1);

  mapf_state_e st_q; // Sequencer state
  mapf_ctrl_s ctrl_q; // Control word
  logic [7:0] win_q; // Programmed window, tenths
  logic [2:0] rsel_q; // Selected range or auto
  logic [SMP_W-1:0] thr_q; // Auto clear threshold
  logic [SMP_W-1:0] lowlim_q; // Lower range limit
  logic [2:0] stat_q; // Sticky status
  logic [2:0] mask_q; // Interrupt mask
  logic [SMP_W-1:0] mem [DEPTH]; // Ring of samples
  logic [LEN_W-1:0] ptr_q; // Ring write slot
  logic [LEN_W-1:0] fill_q; // Samples in window
  logic [LEN_W-1:0] len_q; // Window length last applied
  logic [SUM_W-1:0] sum_q; // Running sum
  logic [SMP_W-1:0] smp_q; // Captured sample
  logic [TCK_W-1:0] tck_q; // Sample period counter
  logic tick_pend_q; // Sample waiting for sequencer
  logic clr_pend_q; // Clear waiting for sequencer
  logic [SUM_W-1:0] num_q; // Divider dividend, then quotient
  logic [LEN_W:0] rem_q; // Divider remainder
  logic [5:0] step_q; // Divider step count
  logic [GAP_W-1:0] gap_q; // Output spacing count
  logic [SMP_W-1:0] avg_q; // Last average
  logic avg_valid_q; // Average strobe
  logic smp_take_q; // Sample capture strobe
  logic uncal_q; // Uncalibrated flag
  logic irq_q; // Interrupt line
  logic [31:0] prdata_q; // Read data
  logic pready_q; // Access phase ready
  logic pslverr_q; // Unmapped access
  logic [2:0] rng; // Effective range
  logic hold; // Fixed range mode
  logic [7:0] eff_win; // Window actually used
  logic [LEN_W-1:0] len; // Window in samples, at least one
  logic apb_wr; // Write takes effect
  logic apb_rd; // Read completes
  logic full; // Window full
  logic big_step; // Large power change
  logic [SMP_W-1:0] diff; // Sample to average distance
  logic [LEN_W:0] trial; // Divider trial remainder
  logic ev_out; // Output issued this cycle
  logic ev_auto; // Auto clear this cycle
  logic ev_uncal; // Uncal flag rising

  // Fixed range when a range is selected, else follow the front end
  assign hold = (rsel_q != MAPF_RANGE_AUTO);
  assign rng = hold ? rsel_q : meas_range;

  // Default or programmed window, in samples
  always_comb begin
    if (!ctrl_q.use_def) begin
      eff_win = win_q;
    end else if (rng == 3'h0) begin
      eff_win = MAPF_WIN_R0;
    end else if (rng == MAPF_RANGE_1 || !ctrl_q.fast) begin
      eff_win = MAPF_WIN_R1;
    end else begin
      eff_win = MAPF_WIN_FAST;
    end
    len = LEN_W'(eff_win * MAPF_SMP_PER_TENTH);
    if (len == '0) begin
      len = LEN_W'(1);
    end
  end

  assign full = (fill_q == len_q);
  assign diff = (smp_q > avg_q) ? smp_q - avg_q : avg_q - smp_q;
  assign big_step = ctrl_q.auto_en && (fill_q != '0) && (diff > thr_q);
  assign trial = {rem_q[LEN_W-1:0], num_q[SUM_W-1]};
  assign apb_wr = psel && penable && pready_q && pwrite;
  assign apb_rd = psel && penable && pready_q && !pwrite;
  assign ev_out = (st_q == MAPF_OUT) && (gap_q == '0) && !(ctrl_q.settled && !full);
  assign ev_auto = (st_q == MAPF_IDLE) && !clr_pend_q && tick_pend_q && big_step;
  assign ev_uncal = smp_take_q && hold && (smp_q < lowlim_q) && !uncal_q;

  // Sample period timer; the capture strobe latches the front end
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      tck_q <= '0;
      smp_take_q <= 1'b0;
      smp_q <= '0;
    end else begin
      smp_take_q <= 1'b0;
      if (tck_q == TCK_W'(SMP_CYC - 1)) begin
        tck_q <= '0;
        smp_take_q <= 1'b1;
        smp_q <= smp_data;
      end else begin
        tck_q <= tck_q + TCK_W'(1);
      end
    end
  end

  // Pending sample and clear requests; a new request beats consumption
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      tick_pend_q <= 1'b0;
      clr_pend_q <= 1'b1;
    end else begin
      if (smp_take_q) begin
        tick_pend_q <= 1'b1;
      end else if (st_q == MAPF_IDLE && !clr_pend_q) begin
        tick_pend_q <= 1'b0;
      end
      if (trig) begin
        clr_pend_q <= 1'b1;
      end else if (apb_wr && paddr == MAPF_OFS_WIN && pwdata[7:0] != win_q) begin
        clr_pend_q <= 1'b1;
      end else if (apb_wr && paddr == MAPF_OFS_CMD && pwdata[MAPF_CMD_CLR_BIT]) begin
        clr_pend_q <= 1'b1;
      end else if (len != len_q) begin
        clr_pend_q <= 1'b1;
      end else if (st_q == MAPF_IDLE) begin
        clr_pend_q <= 1'b0;
      end
    end
  end

  // Ring buffer write; an auto clear restarts the ring at slot zero
  always_ff @(posedge mclk) begin
    if (st_q == MAPF_IDLE && !clr_pend_q && tick_pend_q) begin
      mem[big_step ? LEN_W'(0) : ptr_q] <= smp_q;
    end
  end

  // Running sum, fill count and ring pointer
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      sum_q <= '0;
      fill_q <= '0;
      ptr_q <= '0;
      len_q <= LEN_W'(1);
    end else if (st_q == MAPF_IDLE) begin
      if (clr_pend_q) begin
        sum_q <= '0;
        fill_q <= '0;
        ptr_q <= '0;
        len_q <= len;
      end else if (tick_pend_q) begin
        ptr_q <= (ptr_q == len_q - LEN_W'(1)) ? '0 : ptr_q + LEN_W'(1);
        if (big_step) begin
          sum_q <= SUM_W'(smp_q);
          fill_q <= LEN_W'(1);
          ptr_q <= LEN_W'(1) == len_q ? '0 : LEN_W'(1);
        end else if (full) begin
          sum_q <= sum_q + SUM_W'(smp_q) - SUM_W'(mem[ptr_q]);
        end else begin
          sum_q <= sum_q + SUM_W'(smp_q);
          fill_q <= fill_q + LEN_W'(1);
        end
      end
    end
  end

  // Sequencer: accumulate, divide by fill count, then issue
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      st_q <= MAPF_IDLE;
      num_q <= '0;
      rem_q <= '0;
      step_q <= '0;
    end else begin
      case (st_q)
        MAPF_IDLE: begin
          // Start the division after the sum has been updated
          if (!clr_pend_q && tick_pend_q) begin
            st_q <= MAPF_DIV;
            step_q <= '0;
            rem_q <= '0;
          end
        end
        MAPF_DIV: begin
          // Restoring division, one quotient bit per cycle
          if (step_q == 6'h0 && rem_q == '0 && num_q != sum_q && fill_q != '0) begin
            num_q <= sum_q;
            step_q <= 6'h1;
          end else if (step_q == 6'h0) begin
            num_q <= sum_q;
            step_q <= 6'h1;
          end else if (step_q == 6'(SUM_W + 1)) begin
            st_q <= MAPF_OUT;
          end else begin
            step_q <= step_q + 6'h1;
            if (trial >= {1'b0, fill_q}) begin
              rem_q <= trial - {1'b0, fill_q};
              num_q <= {num_q[SUM_W-2:0], 1'b1};
            end else begin
              rem_q <= trial;
              num_q <= {num_q[SUM_W-2:0], 1'b0};
            end
          end
        end
        MAPF_OUT: begin
          // Wait for output spacing; settled mode may drop the update
          if (gap_q == '0) begin
            st_q <= MAPF_IDLE;
          end
        end
        default: begin
          st_q <= MAPF_IDLE;
        end
      endcase
    end
  end

  // Filtered output and its spacing counter
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      avg_q <= '0;
      avg_valid_q <= 1'b0;
      gap_q <= '0;
    end else begin
      avg_valid_q <= 1'b0;
      if (ev_out) begin
        avg_q <= num_q[SMP_W-1:0];
        avg_valid_q <= 1'b1;
        gap_q <= GAP_W'(OUT_GAP_CYC - 1);
      end else if (gap_q != '0) begin
        gap_q <= gap_q - GAP_W'(1);
      end
    end
  end

  // Uncalibrated flag, updated each sample, dropped outside fixed range
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      uncal_q <= 1'b0;
    end else if (!hold) begin
      uncal_q <= 1'b0;
    end else if (smp_take_q) begin
      uncal_q <= (smp_q < lowlim_q);
    end
  end

  // Sticky status, read clears, set wins; interrupt from masked status
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      stat_q <= '0;
      irq_q <= 1'b0;
    end else begin
      stat_q <= ((apb_rd && paddr == MAPF_OFS_STAT) ? 3'h0 : stat_q) | {ev_uncal, ev_auto, ev_out};
      irq_q <= |(stat_q & mask_q);
    end
  end

  // Software-written registers
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      ctrl_q <= MAPF_CTRL_RST;
      win_q <= MAPF_WIN_R1;
      rsel_q <= MAPF_RANGE_RST[2:0];
      thr_q <= '0;
      lowlim_q <= '0;
      mask_q <= MAPF_MASK_RST;
    end else if (apb_wr) begin
      case (paddr)
        MAPF_OFS_CTRL: ctrl_q <= pwdata[3:0];
        MAPF_OFS_WIN: win_q <= (pwdata[7:0] > MAPF_WIN_MAX) ? MAPF_WIN_MAX : pwdata[7:0];
        MAPF_OFS_RANGE: rsel_q <= pwdata[2:0];
        MAPF_OFS_THR: thr_q <= pwdata[SMP_W-1:0];
        MAPF_OFS_LOWLIM: lowlim_q <= pwdata[SMP_W-1:0];
        MAPF_OFS_MASK: mask_q <= pwdata[2:0];
        default: begin
        end
      endcase
    end
  end

  // APB setup phase: decode, load read data, answer next cycle
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      prdata_q <= '0;
      pready_q <= 1'b0;
      pslverr_q <= 1'b0;
    end else begin
      pready_q <= psel && !penable;
      pslverr_q <= 1'b0;
      if (psel && !penable) begin
        prdata_q <= '0;
        case (paddr)
          MAPF_OFS_CTRL: prdata_q <= {28'h0, ctrl_q};
          MAPF_OFS_WIN: prdata_q <= {24'h0, win_q};
          MAPF_OFS_RANGE: prdata_q <= {29'h0, rsel_q};
          MAPF_OFS_THR: prdata_q <= 32'(thr_q);
          MAPF_OFS_LOWLIM: prdata_q <= 32'(lowlim_q);
          MAPF_OFS_CMD: prdata_q <= '0;
          MAPF_OFS_AVG: prdata_q <= 32'(avg_q);
          MAPF_OFS_STAT: prdata_q <= {29'h0, stat_q};
          MAPF_OFS_MASK: prdata_q <= {29'h0, mask_q};
          MAPF_OFS_FILL: prdata_q <= {7'h0, len_q, 7'h0, fill_q};
          default: pslverr_q <= 1'b1;
        endcase
      end
    end
  end

  assign prdata = prdata_q;
  assign pready = pready_q;
  assign pslverr = pslverr_q;
  assign smp_take = smp_take_q;
  assign avg_data = avg_q;
  assign avg_valid = avg_valid_q;
  assign uncal = uncal_q;
  assign irq = irq_q;

  // Helper: cycles since the last output, saturating
  logic [GAP_W:0] since_q;
  always_ff @(posedge mclk) begin
    if (!rst_n || avg_valid_q) begin
      since_q <= '0;
    end else if (since_q != '1) begin
      since_q <= since_q + (GAP_W + 1)'(1);
    end
  end
  logic seen_out_q;
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      seen_out_q <= 1'b0;
    end else if (avg_valid_q) begin
      seen_out_q <= 1'b1;
    end
  end

  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rst_n);

  a_fill_bounded: assert property (fill_q <= len_q) else $error("fill exceeds window");
  a_win_range: assert property (win_q <= MAPF_WIN_MAX) else $error("window above twenty seconds");
  a_trig_clears: assert property (trig |-> ##[1:40] fill_q == '0) else $error("trigger did not clear");
  a_out_spacing: assert property (avg_valid_q && seen_out_q |-> since_q >= (GAP_W + 1)'(OUT_GAP_CYC - 1))
    else $error("outputs too close");
  a_settled_hold: assert property (avg_valid_q && ctrl_q.settled |-> fill_q == len_q)
    else $error("unsettled output issued");
  a_uncal_fixed: assert property (!hold |=> !uncal_q) else $error("uncal outside fixed range");
  a_full_displace: assert property (st_q == MAPF_IDLE && !clr_pend_q && tick_pend_q && full && !big_step
    |=> fill_q == $past(fill_q)) else $error("full window grew");
  a_first_mean: assert property (avg_valid_q && fill_q == LEN_W'(1) |-> avg_q == mem[0])
    else $error("single sample mean wrong");
  a_default_win: assert property (ctrl_q.use_def && rng == 3'h0 |-> len == LEN_W'(56))
    else $error("range zero default wrong");
  a_fast_zero: assert property (ctrl_q.use_def && ctrl_q.fast && rng > MAPF_RANGE_1 && rng != MAPF_RANGE_AUTO
    |-> len == LEN_W'(1)) else $error("fast default wrong");
  a_win_write: assert property (apb_wr && paddr == MAPF_OFS_WIN && pwdata[7:0] != win_q |=> clr_pend_q)
    else $error("window change did not clear");
  a_sample_out: assert property (smp_take_q |-> ##[1:40] (st_q == MAPF_OUT))
    else $error("sample not processed");

  c_output: cover property (avg_valid_q && full);
  c_auto_clr: cover property (ev_auto);
  c_uncal: cover property ($rose(uncal_q));
  c_irq: cover property ($rose(irq_q));
endmodule

// ===== verif/mapf_src.sv
// Front-end sample source model facing the power filter
`timescale 1ns/1ns
module mapf_src
  import mapf_pkg::*;
#(
  parameter int unsigned SMP_W = 16
) (
  input wire logic mclk,
  input wire logic [SMP_W-1:0] lvl, // Power level the bench asks for
  input wire logic [2:0] rng, // Range the front end reports
  output logic [SMP_W-1:0] smp_data,
  output logic [2:0] meas_range
);
  // Registered front end; the bench moves the level only between captures
  always_ff @(posedge mclk) begin
    smp_data <= lvl;
    meas_range <= rng;
  end
endmodule

// ===== verif/mapf_filter_tb_top.sv
// Self-checking bench of the moving-average power filter
`timescale 1ns/1ns
`define CHK(nm, ex, ac) begin total_checks++; if ((ac) !== (ex)) begin error_cnt++; \
  $display("ERROR %s exp %0d got %0d", nm, ex, ac); end end
module mapf_filter_tb_top
  import mapf_pkg::*;
;
  localparam int unsigned SCYC = 200; // Short sample period
  localparam int unsigned GCYC = 50; // Short output spacing
  logic mclk, rst_n, psel, penable, pwrite, pready, pslverr, last_err;
  logic trig, smp_take, avg_valid, uncal, irq;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata;
  logic [15:0] smp_data, avg_data, lvl;
  logic [2:0] meas_range, rng;
  int error_cnt = 0;
  int total_checks = 0;
  int gap = 1000; // Cycles since the last output

  mapf_filter #(.SMP_W(16), .SMP_CYC(SCYC), .OUT_GAP_CYC(GCYC)) i_dut (
    .mclk(mclk), .rst_n(rst_n), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .smp_data(smp_data), .meas_range(meas_range), .trig(trig), .smp_take(smp_take),
    .avg_data(avg_data), .avg_valid(avg_valid), .uncal(uncal), .irq(irq)
  );
  mapf_src #(.SMP_W(16)) i_src (
    .mclk(mclk), .lvl(lvl), .rng(rng), .smp_data(smp_data), .meas_range(meas_range)
  );

  // Clock, 40 ns period
  initial begin
    mclk = 1'h0;
    forever #20 mclk = ~mclk;
  end

  // Verdict and end of run
  task automatic finish_test;
    $display("checks %0d mismatches %0d", total_checks, error_cnt);
    if (error_cnt == 0 && total_checks > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask

  // One APB transfer, held until pready, then one idle cycle
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] r);
    psel <= 1'h1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge mclk);
    penable <= 1'h1;
    do begin
      @(posedge mclk);
    end while (pready !== 1'h1);
    r = prdata;
    last_err = pslverr;
    psel <= 1'h0;
    penable <= 1'h0;
    @(posedge mclk);
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] r;
    apb(1'h1, a, d, r);
  endtask

  task automatic rd(input logic [7:0] a, output logic [31:0] r);
    apb(1'h0, a, 32'h0, r);
  endtask

  // Wait for the next average, bounded
  task automatic wait_avg(output logic [15:0] a);
    int n;
    n = 0;
    do begin
      @(posedge mclk);
      n++;
    end while (avg_valid !== 1'h1 && n < 600);
    `CHK("avg_valid", 1'h1, avg_valid)
    a = avg_data;
  endtask

  // One level per sample period, average checked after each
  task automatic feed(input int v[$], input int e[$]);
    logic [15:0] a;
    for (int i = 0; i < v.size(); i++) begin
      lvl <= 16'(v[i]);
      wait_avg(a);
      `CHK("avg_data", 16'(e[i]), a)
    end
  endtask

  // Reset values and an unmapped offset
  task automatic t_regs;
    logic [31:0] r;
    rd(MAPF_OFS_CTRL, r);
    `CHK("ctrl", 32'h4, r)
    rd(MAPF_OFS_WIN, r);
    `CHK("win", 32'h8, r)
    rd(MAPF_OFS_RANGE, r);
    `CHK("range", 32'h7, r)
    rd(MAPF_OFS_MASK, r);
    `CHK("mask", 32'h0, r)
    rd(8'h40, r);
    `CHK("pslverr", 1'h1, last_err)
    `CHK("bad_rd", 32'h0, r)
    $display("test regs done");
  endtask

  // Fill phase, full window, step ramp, same-length write
  task automatic t_fill;
    logic [15:0] a;
    logic [31:0] r;
    wait_avg(a);
    wr(MAPF_OFS_CTRL, 32'h0);
    wr(MAPF_OFS_WIN, 32'h2);
    feed('{100, 200, 300, 400, 500, 600, 1000, 1000, 1000, 1000},
         '{100, 150, 200, 250, 350, 450, 625, 775, 900, 1000});
    rd(MAPF_OFS_FILL, r);
    `CHK("fill", 9'h4, r[8:0])
    `CHK("win_used", 9'h4, r[24:16])
    wr(MAPF_OFS_WIN, 32'h2);
    rd(MAPF_OFS_FILL, r);
    `CHK("fill_same", 9'h4, r[8:0])
    $display("test fill done");
  endtask

  // Trigger empties the window
  task automatic t_trig;
    logic [31:0] r;
    trig <= 1'h1;
    @(posedge mclk);
    trig <= 1'h0;
    repeat (40) @(posedge mclk);
    rd(MAPF_OFS_FILL, r);
    `CHK("fill_trig", 9'h0, r[8:0])
    feed('{300}, '{300});
    $display("test trig done");
  endtask

  // Auto clear, sticky status, mask and interrupt
  task automatic t_auto;
    logic [31:0] r;
    wr(MAPF_OFS_CTRL, 32'h1);
    wr(MAPF_OFS_THR, 32'h32);
    wr(MAPF_OFS_MASK, 32'h2);
    feed('{300, 2000}, '{300, 2000});
    repeat (3) @(posedge mclk);
    `CHK("irq_on", 1'h1, irq)
    rd(MAPF_OFS_STAT, r);
    `CHK("stat_auto", 1'h1, r[1])
    repeat (2) @(posedge mclk);
    `CHK("irq_clr", 1'h0, irq)
    wr(MAPF_OFS_MASK, 32'h0);
    feed('{100}, '{100});
    repeat (3) @(posedge mclk);
    `CHK("irq_mask", 1'h0, irq)
    wr(MAPF_OFS_MASK, 32'h2);
    repeat (2) @(posedge mclk);
    `CHK("irq_unmask", 1'h1, irq)
    rd(MAPF_OFS_STAT, r);
    wr(MAPF_OFS_CTRL, 32'h0);
    $display("test auto done");
  endtask

  // Below-limit flag in fixed range only
  task automatic t_uncal;
    logic [31:0] r;
    wr(MAPF_OFS_LOWLIM, 32'h3e8);
    wr(MAPF_OFS_RANGE, 32'h3);
    feed('{500}, '{300});
    repeat (2) @(posedge mclk);
    `CHK("uncal_on", 1'h1, uncal)
    rd(MAPF_OFS_STAT, r);
    `CHK("stat_uncal", 1'h1, r[2])
    wr(MAPF_OFS_RANGE, 32'h7);
    repeat (2) @(posedge mclk);
    `CHK("uncal_auto", 1'h0, uncal)
    $display("test uncal done");
  endtask

  // Default windows per range in normal and fast mode
  task automatic t_def;
    logic [31:0] r;
    int e;
    for (int f = 0; f < 2; f++) begin
      for (int g = 0; g < 7; g++) begin
        wr(MAPF_OFS_CTRL, 32'(4 + 2 * f));
        wr(MAPF_OFS_RANGE, 32'(g));
        repeat (40) @(posedge mclk);
        rd(MAPF_OFS_FILL, r);
        e = (g == 0) ? 56 : ((f == 1 && g > 1) ? 1 : 16);
        `CHK("def_win", 9'(e), r[24:16])
      end
    end
    rng <= 3'h0;
    wr(MAPF_OFS_RANGE, 32'h7);
    repeat (40) @(posedge mclk);
    rd(MAPF_OFS_FILL, r);
    `CHK("auto_win", 9'h38, r[24:16])
    $display("test defaults done");
  endtask

  // Settled mode holds outputs until the window is full
  task automatic t_settled;
    logic [15:0] a;
    int n;
    n = 0;
    wr(MAPF_OFS_CTRL, 32'h0);
    wait_avg(a);
    wr(MAPF_OFS_WIN, 32'h1);
    wr(MAPF_OFS_CTRL, 32'h8);
    lvl <= 16'h190;
    repeat (250) begin
      @(posedge mclk);
      if (avg_valid === 1'h1) n++;
    end
    `CHK("held_outs", 0, n)
    feed('{800}, '{600});
    $display("test settled done");
  endtask

  // Zero-length window and saturation of the length
  task automatic t_zero;
    logic [31:0] r;
    wr(MAPF_OFS_CTRL, 32'h0);
    wr(MAPF_OFS_WIN, 32'h0);
    feed('{700, 900}, '{700, 900});
    wr(MAPF_OFS_WIN, 32'hc9);
    rd(MAPF_OFS_WIN, r);
    `CHK("win_sat", 32'hc8, r)
    $display("test zero done");
  endtask

  // Output spacing monitor
  always @(posedge mclk) begin
    if (avg_valid === 1'h1) begin
      `CHK("out_gap", 1'h1, 1'(gap >= GCYC - 1))
      gap <= 0;
    end else begin
      gap <= gap + 1;
    end
  end

  // Capture strobe period monitor
  int sgap = 0; // Cycles since the last capture strobe
  always @(posedge mclk) begin
    if (smp_take === 1'h1) begin
      if (sgap > 0) `CHK("smp_period", SCYC, sgap)
      sgap <= 1;
    end else if (sgap > 0) begin
      sgap <= sgap + 1;
    end
  end

  // Watchdog
  initial begin
    repeat (30000) @(posedge mclk);
    error_cnt++;
    $display("ERROR watchdog exp done got timeout");
    finish_test;
  end

  // Main sequence
  initial begin
    rst_n = 1'h0;
    psel = 1'h0;
    penable = 1'h0;
    pwrite = 1'h0;
    paddr = 8'h0;
    pwdata = 32'h0;
    trig = 1'h0;
    lvl = 16'h0;
    rng = 3'h0;
    repeat (8) @(posedge mclk);
    rst_n <= 1'h1;
    @(posedge mclk);
    t_regs;
    t_fill;
    t_trig;
    t_auto;
    t_uncal;
    t_def;
    t_settled;
    t_zero;
    finish_test;
  end
endmodule
